// [hb_pkg.sv]
// types shared by the host parallel bus front end
package hb_pkg;

	// access sequencer states, one-hot
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_READ  = 3'b010,
		ST_WRITE = 3'b100
	} hbState_t;

endpackage

// [host_bus_map.svh]
// constants for the host parallel bus front end
`ifndef HOST_BUS_MAP_SVH
`define HOST_BUS_MAP_SVH

// ------------------------------------------------------------
// widths
// ------------------------------------------------------------
`define HB_ADDR_W      16
`define HB_DATA_W      32
`define HB_HALF_W      16
`define HB_SYNC_W      54

// ------------------------------------------------------------
// field positions inside the pin synchroniser vector
// ------------------------------------------------------------
`define HB_SY_RSTN     53
`define HB_SY_CSN      52
`define HB_SY_OEN      51
`define HB_SY_WEN      50
`define HB_SY_ALE      49
`define HB_SY_ADDR_HI  48
`define HB_SY_ADDR_LO  36
`define HB_SY_DATA_HI  35
`define HB_SY_DATA_LO  4
`define HB_SY_PTP3     3
`define HB_SY_MUX      2
`define HB_SY_BORD     1
`define HB_SY_SIZE32   0

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define HB_STRAP_RST   3'h0
`define HB_ADDR_RST    16'h0000
`define HB_DATA_RST    32'h00000000
`define HB_TIMER_RST   4'h0

`endif

// [host_bus_strap_cycle.sv]
// host parallel bus front end: straps, chip-select framed access, timer pins
//
// What this block does
// R01 - the address is latched at the falling edge of the active-low chip select.
// R02 - an access ends at the rising edge of chip select, where the device finishes it.
// R03 - while the reset pin is low every register after the pin synchronisers initialises and the straps are sampled.
// R04 - the byte-order strap is held at reset release: high little-endian, low big-endian.
// R05 - the width strap is held at reset release: high 32-bit data bus, low 16-bit.
// R06 - the multiplex strap is held at reset release: high multiplexed, low separate address.
// R07 - in separate-address mode the word-aligned address comes from the address pins, with bit two on the latch strobe pin.
// R08 - in multiplexed mode the address pins are ignored and the address comes off the data lines.
// R09 - timer pins four to seven are outputs that follow the precision timer waveforms.
// R10 - timer pin three is either an output of the precision timer or an input to it.
// R11 - the data lines are driven only while output enable is held low by the host.
// R12 - the host holds write enable low for a write and high for a read over the access.
// R13 - in multiplexed mode the host marks the address phase with the latch strobe pin.
// R14 - data outputs stay released whenever chip select or output enable is inactive.
`timescale 1ns/1ps
`include "host_bus_map.svh"

module host_bus_strap_cycle (
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  srst,
	input  wire logic                  resetPinN,
	// strap pins
	input  wire logic                  muxBusStrap,
	input  wire logic                  byteOrderStrap,
	input  wire logic                  busSize32Strap,
	// host bus control pins
	input  wire logic                  csN,
	input  wire logic                  oeN,
	input  wire logic                  weN,
	input  wire logic                  addrLatchStrobe,
	input  wire logic [15:3]           addrLines,
	// host data pins
	input  wire logic [31:0]           dataIn,
	output logic      [31:0]           dataOut,
	output logic      [1:0]            dataOe,
	// latched configuration
	output logic                       muxMode,
	output logic                       littleEndian,
	output logic                       bus32,
	// internal register side
	output logic      [15:0]           regAddr,
	output logic                       regRead,
	output logic                       regWrite,
	output logic      [31:0]           regWrData,
	input  wire logic [31:0]           regRdData,
	output logic                       accessDone,
	// precision timer side
	input  wire logic [3:0]            timerWave,
	input  wire logic                  timerWave3,
	input  wire logic                  ptp3AsInput,
	output logic                       ptpCapture3,
	// timer pins
	output logic                       ptpSyncPin3Out,
	output logic                       ptpSyncPin3Oe,
	input  wire logic                  ptpSyncPin3In,
	output logic                       ptpSyncPin4,
	output logic                       ptpSyncPin5,
	output logic                       ptpSyncPin6,
	output logic                       ptpSyncPin7
);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [`HB_SYNC_W-1:0] pinRaw;
	logic [`HB_SYNC_W-1:0] pinSync;

	assign pinRaw = {resetPinN, csN, oeN, weN, addrLatchStrobe, addrLines, dataIn,
		ptpSyncPin3In, muxBusStrap, byteOrderStrap, busSize32Strap};

	sync_2ff #(
		.WIDTH   (`HB_SYNC_W)
	) u_sync (
		.clk_sys (clk_sys),
		.asyncIn (pinRaw),
		.syncOut (pinSync)
	);

	wire        rstPinS = pinSync[`HB_SY_RSTN];
	wire        csS     = pinSync[`HB_SY_CSN];
	wire        oeS     = pinSync[`HB_SY_OEN];
	wire        weS     = pinSync[`HB_SY_WEN];
	wire        aleS    = pinSync[`HB_SY_ALE];
	wire [15:3] addrS   = pinSync[`HB_SY_ADDR_HI:`HB_SY_ADDR_LO];
	wire [31:0] dataS   = pinSync[`HB_SY_DATA_HI:`HB_SY_DATA_LO];
	wire        ptp3S   = pinSync[`HB_SY_PTP3];
	wire [2:0]  strapS  = pinSync[`HB_SY_MUX:`HB_SY_SIZE32];

	// the pin reset and the system reset act alike on every register
	wire devRst = srst | ~rstPinS;

	// ------------------------------------------------------------
	// straps
	// ------------------------------------------------------------
	logic [2:0] strap_q;

	// straps track the pins during reset, so the last reset cycle holds the release value
	always_ff @(posedge clk_sys) begin
		if (devRst) begin
			strap_q <= strapS; // see R03, see R04, see R05, see R06
		end
	end

	assign muxMode      = strap_q[2];
	assign littleEndian = strap_q[1];
	assign bus32        = strap_q[0];

	// ------------------------------------------------------------
	// edge detection and address selection
	// ------------------------------------------------------------
	logic       csPrev_q;
	logic       ptp3Prev_q;
	logic [15:0] muxAddr_q;

	wire csFall = csPrev_q & ~csS;
	wire csRise = ~csPrev_q & csS;

	// in multiplexed mode the latch strobe pin is not an address bit
	wire [15:0] sepAddr = {addrS, aleS, 2'b00};                  // see R07
	wire [15:0] muxAddr = {muxAddr_q[15:2], 2'b00};              // see R08
	wire [15:0] addrSel = muxMode ? muxAddr : sepAddr;

	always_ff @(posedge clk_sys) begin
		if (devRst) begin
			csPrev_q   <= 1'b1;
			ptp3Prev_q <= 1'b0;
			muxAddr_q  <= `HB_ADDR_RST;
		end else begin
			csPrev_q   <= csS;
			ptp3Prev_q <= ptp3S;
			if (muxMode && aleS) begin
				muxAddr_q <= dataS[15:0]; // see R08, see R13
			end
		end
	end

	// ------------------------------------------------------------
	// byte order and width
	// ------------------------------------------------------------
	// internal side is little endian; big endian swaps bytes within the bus width
	function automatic logic [31:0] orderBytes(input logic [31:0] d, input logic lit,
		input logic wide);
		logic [31:0] r;
		r = 32'h00000000;
		if (!wide) begin
			r[15:0] = lit ? d[15:0] : {d[7:0], d[15:8]};
		end else begin
			r = lit ? d : {d[7:0], d[15:8], d[23:16], d[31:24]};
		end
		return r;
	endfunction

	wire [31:0] wrOrdered = orderBytes(dataS, littleEndian, bus32);         // see R04, see R05
	wire [31:0] rdOrdered = orderBytes(regRdData, littleEndian, bus32);

	// ------------------------------------------------------------
	// access sequencer
	// ------------------------------------------------------------
	hb_pkg::hbState_t state_q;
	hb_pkg::hbState_t state_d;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			hb_pkg::ST_IDLE: begin
				if (csFall) begin
					state_d = weS ? hb_pkg::ST_READ : hb_pkg::ST_WRITE; // see R12
				end
			end
			hb_pkg::ST_READ: begin
				if (csRise) begin
					state_d = hb_pkg::ST_IDLE; // see R02
				end
			end
			hb_pkg::ST_WRITE: begin
				if (csRise) begin
					state_d = hb_pkg::ST_IDLE; // see R02
				end
			end
			default: state_d = hb_pkg::ST_IDLE;
		endcase
	end

	logic        rdPend_q;
	logic [31:0] readData_q;

	always_ff @(posedge clk_sys) begin
		if (devRst) begin
			state_q    <= hb_pkg::ST_IDLE; // see R03
			regAddr    <= `HB_ADDR_RST;
			regRead    <= 1'b0;
			regWrite   <= 1'b0;
			regWrData  <= `HB_DATA_RST;
			accessDone <= 1'b0;
			rdPend_q   <= 1'b0;
			readData_q <= `HB_DATA_RST;
		end else begin
			state_q    <= state_d;
			regRead    <= (state_q == hb_pkg::ST_IDLE) && csFall && weS;
			regWrite   <= (state_q == hb_pkg::ST_WRITE) && csRise; // see R02
			accessDone <= (state_q != hb_pkg::ST_IDLE) && csRise;  // see R02
			rdPend_q   <= regRead;
			if ((state_q == hb_pkg::ST_IDLE) && csFall) begin
				regAddr <= addrSel; // see R01
			end
			if ((state_q == hb_pkg::ST_WRITE) && csRise) begin
				regWrData <= wrOrdered;
			end
			if (rdPend_q) begin
				readData_q <= rdOrdered;
			end
		end
	end

	// ------------------------------------------------------------
	// data drivers
	// ------------------------------------------------------------
	// enables follow the synchronised pins, so release lags the host by two
	// cycles; the host must allow that turnaround before it drives the bus
	wire driveEn = (state_q == hb_pkg::ST_READ) & ~csS & ~oeS; // see R11, see R14

	assign dataOut = readData_q;
	assign dataOe  = {driveEn & bus32, driveEn}; // see R05

	// ------------------------------------------------------------
	// timer pins
	// ------------------------------------------------------------
	logic [3:0] timerOut_q;
	logic       ptp3Out_q;
	logic       ptp3Oe_q;
	logic       ptpCap_q;

	genvar ti;
	generate
		for (ti = 0; ti < 4; ti = ti + 1) begin : g_timer
			always_ff @(posedge clk_sys) begin
				if (devRst) begin
					timerOut_q[ti] <= 1'b0;
				end else begin
					timerOut_q[ti] <= timerWave[ti]; // see R09
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (devRst) begin
			ptp3Out_q <= 1'b0;
			ptp3Oe_q  <= 1'b0;
			ptpCap_q  <= 1'b0;
		end else begin
			ptp3Out_q <= timerWave3;
			ptp3Oe_q  <= ~ptp3AsInput;                         // see R10
			ptpCap_q  <= ptp3AsInput & ptp3S & ~ptp3Prev_q;     // see R10
		end
	end

	assign ptpSyncPin4    = timerOut_q[0];
	assign ptpSyncPin5    = timerOut_q[1];
	assign ptpSyncPin6    = timerOut_q[2];
	assign ptpSyncPin7    = timerOut_q[3];
	assign ptpSyncPin3Out = ptp3Out_q;
	assign ptpSyncPin3Oe  = ptp3Oe_q;
	assign ptpCapture3    = ptpCap_q;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_addrLatch;
		@(posedge clk_sys) disable iff (devRst)
		(state_q == hb_pkg::ST_IDLE) && csFall |=> regAddr == $past(addrSel);
	endproperty
	a_addrLatch: assert property (p_addrLatch) else $error("address not latched at cs fall"); // see R01

	property p_writeAtRise;
		@(posedge clk_sys) disable iff (devRst)
		(state_q == hb_pkg::ST_WRITE) && csRise |=> regWrite && accessDone
			&& state_q == hb_pkg::ST_IDLE;
	endproperty
	a_writeAtRise: assert property (p_writeAtRise) else $error("write not finished at cs rise"); // see R02

	property p_writeOnlyRise;
		@(posedge clk_sys) disable iff (devRst)
		regWrite |-> $past(csRise) && !$past(csS, 2);
	endproperty
	a_writeOnlyRise: assert property (p_writeOnlyRise) else $error("write strobe without cs rise"); // see R02

	property p_resetIdle;
		@(posedge clk_sys) disable iff (srst)
		devRst |=> state_q == hb_pkg::ST_IDLE && !regWrite && !regRead && dataOe == 2'b00;
	endproperty
	a_resetIdle: assert property (p_resetIdle) else $error("state not cleared by reset"); // see R03

	// the synchronisers hold unknowns for the first cycles of system reset
	property p_strapCapture;
		@(posedge clk_sys) disable iff (srst)
		devRst |=> {muxMode, littleEndian, bus32} == $past(strapS);
	endproperty
	a_strapCapture: assert property (p_strapCapture) else $error("strap not sampled in reset"); // see R06

	property p_strapHold;
		@(posedge clk_sys) disable iff (devRst)
		!$past(devRst) |-> $stable(littleEndian) && $stable(bus32) && $stable(muxMode);
	endproperty
	a_strapHold: assert property (p_strapHold) else $error("strap changed outside reset"); // see R04

	property p_narrowBus;
		@(posedge clk_sys) disable iff (devRst)
		!bus32 |-> !dataOe[1] && readData_q[31:16] == 16'h0000;
	endproperty
	a_narrowBus: assert property (p_narrowBus) else $error("upper half used on 16-bit bus"); // see R05

	property p_muxAddr;
		@(posedge clk_sys) disable iff (devRst)
		(state_q == hb_pkg::ST_IDLE) && csFall && muxMode
			|=> regAddr[15:2] == $past(muxAddr_q[15:2]);
	endproperty
	a_muxAddr: assert property (p_muxAddr) else $error("mux address not from data lines"); // see R08

	property p_drive;
		@(posedge clk_sys) disable iff (devRst)
		dataOe != 2'b00 |-> !oeS && !csS && state_q == hb_pkg::ST_READ;
	endproperty
	a_drive: assert property (p_drive) else $error("data driven without cs and oe"); // see R11

	property p_timerOut;
		@(posedge clk_sys) disable iff (devRst)
		!$past(devRst) |-> {ptpSyncPin7, ptpSyncPin6, ptpSyncPin5, ptpSyncPin4}
			== $past(timerWave);
	endproperty
	a_timerOut: assert property (p_timerOut) else $error("timer pins do not follow waveform"); // see R09

	property p_pin3Dir;
		@(posedge clk_sys) disable iff (devRst)
		ptp3AsInput ##1 ptp3AsInput |-> !ptpSyncPin3Oe;
	endproperty
	a_pin3Dir: assert property (p_pin3Dir) else $error("timer pin 3 driven in input mode"); // see R10

endmodule

// [host_model.sv]
// host processor model driving the parallel bus pins
`timescale 1ns/1ps

module host_model (
	// clock
	input  wire logic        clk_sys,
	// bus pins
	output logic             csN,
	output logic             oeN,
	output logic             weN,
	output logic             addrLatchStrobe,
	output logic [15:3]      addrLines,
	output logic [31:0]      dataIn
);
	initial begin
		csN = 1'b1;
		oeN = 1'b1;
		weN = 1'b1;
		addrLatchStrobe = 1'b0;
		addrLines = 13'h0000;
		dataIn = 32'h00000000;
	end

	// one framed access; address and data are held well past the chip-select edges
	// because the device sees every pin through a two-flop synchroniser
	task automatic access(input logic wr, input logic oeLow, input logic mux,
		input logic [15:0] addr, input logic [31:0] data);
		@(posedge clk_sys);
		if (mux) begin
			addrLines <= ~addr[15:3];
			addrLatchStrobe <= 1'b1;
			dataIn <= {16'h0000, addr};
			repeat (3) @(posedge clk_sys);
			addrLatchStrobe <= 1'b0;
		end else begin
			addrLines <= addr[15:3];
			addrLatchStrobe <= addr[2];
		end
		// a released bus shows the inverse pattern, never the last value
		dataIn <= wr ? data : ~data;
		weN <= ~wr;
		@(posedge clk_sys);
		csN <= 1'b0;
		oeN <= ~(oeLow & ~wr);
		repeat (8) @(posedge clk_sys);
		csN <= 1'b1;
		oeN <= 1'b1;
		repeat (5) @(posedge clk_sys);
		dataIn <= ~dataIn;
		weN <= 1'b1;
	endtask
endmodule

// [sync_2ff.sv]
// two-flop synchroniser for a group of asynchronous pin inputs
`timescale 1ns/1ps

module sync_2ff #(
	parameter int WIDTH = 1
) (
	// clock
	input  wire logic             clk_sys,
	// asynchronous side
	input  wire logic [WIDTH-1:0] asyncIn,
	// synchronised side
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1_q;

	// ------------------------------------------------------------
	// one chain per bit; no reset so pins never mix with reset logic
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
			always_ff @(posedge clk_sys) begin
				stage1_q[gi] <= asyncIn[gi];
				syncOut[gi]  <= stage1_q[gi];
			end
		end
	endgenerate

endmodule

// [tb.sv]
// self-checking bench for the host bus front end
`timescale 1ns/1ps

module tb;
	// --------------------------------------------------------
	// signals
	// --------------------------------------------------------
	logic        clk_sys, srst, resetPinN, muxBusStrap, byteOrderStrap, busSize32Strap;
	logic        csN, oeN, weN, addrLatchStrobe, timerWave3, ptp3AsInput, ptpSyncPin3In;
	logic        muxMode, littleEndian, bus32, regRead, regWrite, accessDone, ptpCapture3;
	logic        ptpSyncPin3Out, ptpSyncPin3Oe, ptpSyncPin4, ptpSyncPin5, ptpSyncPin6;
	logic        ptpSyncPin7;
	logic [15:3] addrLines;
	logic [31:0] dataIn, dataOut, regWrData, regRdData, lastWr, lastOut;
	logic [1:0]  dataOe;
	logic [15:0] regAddr;
	logic [3:0]  timerWave;
	int          errors, n_tests, cycles, nWr, nRd, nDone, nCap, nOe0, nOe1;

	host_model i_host_model (.clk_sys(clk_sys), .csN(csN), .oeN(oeN), .weN(weN),
		.addrLatchStrobe(addrLatchStrobe), .addrLines(addrLines), .dataIn(dataIn));

	host_bus_strap_cycle i_host_bus_strap_cycle (.clk_sys(clk_sys), .srst(srst),
		.resetPinN(resetPinN), .muxBusStrap(muxBusStrap), .byteOrderStrap(byteOrderStrap),
		.busSize32Strap(busSize32Strap), .csN(csN), .oeN(oeN), .weN(weN),
		.addrLatchStrobe(addrLatchStrobe), .addrLines(addrLines), .dataIn(dataIn),
		.dataOut(dataOut), .dataOe(dataOe), .muxMode(muxMode), .littleEndian(littleEndian),
		.bus32(bus32), .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite),
		.regWrData(regWrData), .regRdData(regRdData), .accessDone(accessDone),
		.timerWave(timerWave), .timerWave3(timerWave3), .ptp3AsInput(ptp3AsInput),
		.ptpCapture3(ptpCapture3), .ptpSyncPin3Out(ptpSyncPin3Out),
		.ptpSyncPin3Oe(ptpSyncPin3Oe), .ptpSyncPin3In(ptpSyncPin3In),
		.ptpSyncPin4(ptpSyncPin4), .ptpSyncPin5(ptpSyncPin5), .ptpSyncPin6(ptpSyncPin6),
		.ptpSyncPin7(ptpSyncPin7));

	// --------------------------------------------------------
	// register side model and monitors
	// --------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (regRead)
			regRdData <= {~regAddr, regAddr};
		if (regWrite) begin
			nWr <= nWr + 1;
			lastWr <= regWrData;
		end
		if (regRead)
			nRd <= nRd + 1;
		if (accessDone) begin
			nDone <= nDone + 1;
			lastOut <= dataOut;
		end
		if (ptpCapture3)
			nCap <= nCap + 1;
		if (dataOe[0] === 1'b1)
			nOe0 <= nOe0 + 1;
		if (dataOe[1] === 1'b1)
			nOe1 <= nOe1 + 1;
		if (cycles == 5000) begin
			errors++;
			report_and_stop();
		end
	end

	// --------------------------------------------------------
	// tasks
	// --------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		if (errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// big endian swaps bytes inside the active width; 16-bit leaves the top half zero
	function automatic logic [31:0] swapped(input logic [31:0] d, input logic lit,
		input logic b32);
		logic [31:0] s;
		s = b32 ? {d[7:0], d[15:8], d[23:16], d[31:24]} : {16'h0000, d[7:0], d[15:8]};
		if (lit)
			s = b32 ? d : {16'h0000, d[15:0]};
		return s;
	endfunction

	task automatic set_cfg(input logic m, input logic lit, input logic b32);
		@(posedge clk_sys);
		muxBusStrap <= m;
		byteOrderStrap <= lit;
		busSize32Strap <= b32;
		resetPinN <= 1'b0;
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
		check(32'(regAddr), 32'h00000000);
		check(32'(dataOe), 32'h00000000);
		@(posedge clk_sys);
		resetPinN <= 1'b1;
		repeat (2) @(posedge clk_sys);
		// straps moved after release must not reach the latched choice
		muxBusStrap <= ~m;
		byteOrderStrap <= ~lit;
		busSize32Strap <= ~b32;
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
		check(32'(muxMode), 32'(m));
		check(32'(littleEndian), 32'(lit));
		check(32'(bus32), 32'(b32));
	endtask

	task automatic run_pair(input logic m, input logic lit, input logic b32,
		input logic [15:0] addr, input logic [31:0] data);
		int w0, r0, d0, o0, o1;
		logic [15:0] ra;
		w0 = nWr;
		d0 = nDone;
		i_host_model.access(1'b1, 1'b1, m, addr, data);
		@(negedge clk_sys);
		check(32'(nWr - w0), 32'h00000001);
		check(32'(nDone - d0), 32'h00000001);
		check(32'(regAddr), {16'h0000, addr[15:2], 2'b00});
		check(lastWr, swapped(data, lit, b32));
		r0 = nRd;
		o0 = nOe0;
		o1 = nOe1;
		ra = {addr[15:2] ^ 14'h0040, 2'b00};
		i_host_model.access(1'b0, 1'b1, m, ra, data);
		@(negedge clk_sys);
		check(32'(nRd - r0), 32'h00000001);
		check({30'h0, 1'(nOe1 > o1), 1'(nOe0 > o0)}, {30'h0, b32, 1'b1});
		check(32'(dataOe), 32'h00000000);
		check(lastOut & (b32 ? 32'hffffffff : 32'h0000ffff),
			swapped({~ra, ra}, lit, b32));
	endtask

	// --------------------------------------------------------
	// main sequence
	// --------------------------------------------------------
	initial begin
		int c0, o0, o1, r0;
		srst = 1'b1;
		resetPinN = 1'b0;
		muxBusStrap = 1'b0;
		byteOrderStrap = 1'b0;
		busSize32Strap = 1'b0;
		timerWave = 4'h0;
		timerWave3 = 1'b0;
		ptp3AsInput = 1'b0;
		ptpSyncPin3In = 1'b0;
		repeat (8) @(posedge clk_sys);
		srst <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			set_cfg(i[2], i[1], i[0]);
			run_pair(i[2], i[1], i[0], 16'h0027 + 16'(i) * 16'h0400, 32'h11223344 + i);
		end
		// read with output enable withheld: the device must keep off the bus
		r0 = nRd;
		o0 = nOe0;
		o1 = nOe1;
		i_host_model.access(1'b0, 1'b0, 1'b1, 16'h3c28, 32'h0);
		@(negedge clk_sys);
		check(32'(nRd - r0), 32'h00000001);
		check(32'((nOe0 - o0) + (nOe1 - o1)), 32'h00000000);
		// timer pins, pin three first as output then as input
		c0 = nCap;
		@(posedge clk_sys);
		timerWave <= 4'h9;
		timerWave3 <= 1'b1;
		ptpSyncPin3In <= 1'b1;
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
		check(32'({ptpSyncPin7, ptpSyncPin6, ptpSyncPin5, ptpSyncPin4}), 32'h9);
		check(32'({ptpSyncPin3Oe, ptpSyncPin3Out}), 32'h3);
		check(32'(nCap - c0), 32'h0);
		@(posedge clk_sys);
		timerWave <= 4'h6;
		ptp3AsInput <= 1'b1;
		ptpSyncPin3In <= 1'b0;
		repeat (3) @(posedge clk_sys);
		ptpSyncPin3In <= 1'b1;
		repeat (7) @(posedge clk_sys);
		@(negedge clk_sys);
		check(32'({ptpSyncPin7, ptpSyncPin6, ptpSyncPin5, ptpSyncPin4}), 32'h6);
		check(32'(ptpSyncPin3Oe), 32'h0);
		check(32'(nCap - c0), 32'h1);
		report_and_stop();
	end
endmodule
